// ### hw/ufb_top.sv
// Serial transceiver with frame-format and baud divisor configuration.
// Assumes a classic Wishbone master on clk_sys_i and a remote serial node.
`timescale 1ns/1ps
module ufb_top #(
	parameter int FIFO_DEPTH = ufb_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial line
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic sync_serial_clock_o,
	output logic sync_serial_clock_oe_o
);
	localparam int DW = ufb_pkg::DATA_W;

	ufb_pkg::ufb_frame_t frame_r;
	logic rx_en_r;
	logic tx_en_r;
	logic wtop_r;
	logic ds_r;
	logic [ufb_pkg::DIV_HI_W-1:0] baud_hi_r;
	logic [7:0] baud_lo_r;
	logic [ufb_pkg::DIV_W-1:0] div_r;
	logic [ufb_pkg::DIV_W-1:0] cnt_r;
	logic [3:0] ph_r;
	logic sclk_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic rx_s1_r;
	logic rx_s2_r;
	ufb_pkg::ufb_tx_st_t tx_st_r;
	logic [DW-1:0] tx_sh_r;
	logic [3:0] tx_bit_r;
	logic tx_out_r;
	ufb_pkg::ufb_rx_st_t rx_st_r;
	logic [DW-1:0] rx_sh_r;
	logic [3:0] rx_bit_r;
	logic [3:0] rx_os_r;
	logic rx_par_r;
	logic [DW-1:0] rx_data_r;
	logic rx_full_r;
	logic perr_r;

	// Bus decode
	logic req;
	logic go;
	logic wr;
	logic [7:0] adr;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DW-1:0] fifo_out_data;
	logic tx_pop;

	assign adr = {wb_adr_i[7:2], 2'b00};
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	// Tx data writes wait for room in the FIFO
	assign go = req && !(wb_we_i && adr == ufb_pkg::ADR_TX_DATA && !fifo_in_ready);
	assign wr = go && wb_we_i && wb_sel_i[0];

	// Frame configuration decode
	logic is_async;
	logic is_sync;
	logic [2:0] wcode;
	logic [3:0] nb;
	logic [3:0] nb_m1;
	logic par_en;
	logic [3:0] os_m1;
	logic [3:0] half_m1;
	logic tick;
	logic tx_bit_tick;
	logic sync_tx_edge;
	logic sync_rx_edge;
	logic tx_step;
	logic [DW-1:0] mask;
	logic tx_par;
	logic tx_free;

	assign is_async = (frame_r.mode == ufb_pkg::MODE_ASYNC);
	assign is_sync = (frame_r.mode == ufb_pkg::MODE_SYNC);
	assign wcode = {wtop_r, frame_r.width_lo};
	// reserved code 01 leaves parity off
	assign par_en = frame_r.parity[1];

	// data bit count from width code
	always_comb begin
		unique case (wcode)
			ufb_pkg::WID_5: nb = 4'h5;
			ufb_pkg::WID_6: nb = 4'h6;
			ufb_pkg::WID_7: nb = 4'h7;
			ufb_pkg::WID_9: nb = 4'h9;
			default: nb = 4'h8;
		endcase
	end
	assign nb_m1 = nb - 4'h1;
	assign mask = 9'h1FF >> (4'h9 - nb);

	assign os_m1 = ds_r ? ufb_pkg::OS_DBL_M1 : ufb_pkg::OS_NORM_M1;
	assign half_m1 = ds_r ? ufb_pkg::HALF_DBL_M1 : ufb_pkg::HALF_NORM_M1;
	assign tick = (cnt_r == '0);
	assign tx_bit_tick = tick && ph_r >= os_m1;
	// data edge and sample edge chosen by polarity
	assign sync_tx_edge = is_sync && tick && (sclk_r == frame_r.pol);
	assign sync_rx_edge = is_sync && tick && (sclk_r != frame_r.pol);
	assign tx_step = is_async ? tx_bit_tick : sync_tx_edge;
	// next start follows the last stop bit without an idle gap
	assign tx_free = tx_st_r == ufb_pkg::T_IDLE ||
		(tx_st_r == ufb_pkg::T_STOP && !(frame_r.stop2 && tx_bit_r == '0));
	assign tx_pop = tx_free && tx_step && tx_en_r && fifo_out_valid;
	// parity of the masked data bits
	assign tx_par = ^(tx_sh_r & mask) ^ frame_r.parity[0];

	ufb_fifo #(
		.WIDTH(DW),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.in_valid_i(wr && adr == ufb_pkg::ADR_TX_DATA),
		.in_ready_o(fifo_in_ready),
		.in_data_i(wb_dat_i[DW-1:0]),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(tx_pop),
		.out_data_o(fifo_out_data)
	);

	// Configuration registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			frame_r <= ufb_pkg::ufb_frame_t'(ufb_pkg::FRAME_RST);
			rx_en_r <= 1'b0;
			tx_en_r <= 1'b0;
			wtop_r <= 1'b0;
			ds_r <= 1'b0;
		end else if (wr) begin
			if (adr == ufb_pkg::ADR_FRAME) begin
				frame_r <= ufb_pkg::ufb_frame_t'(wb_dat_i[7:0]);
			end
			if (adr == ufb_pkg::ADR_ENABLE) begin
				rx_en_r <= wb_dat_i[ufb_pkg::EN_RX_BIT];
				tx_en_r <= wb_dat_i[ufb_pkg::EN_TX_BIT];
				wtop_r <= wb_dat_i[ufb_pkg::EN_WTOP_BIT];
			end
			if (adr == ufb_pkg::ADR_STATUS) begin
				ds_r <= wb_dat_i[ufb_pkg::ST_DS_BIT];
			end
		end
	end

	// Divisor bytes and prescaler
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			baud_hi_r <= '0;
			baud_lo_r <= '0;
			div_r <= ufb_pkg::DIV_RST;
			cnt_r <= ufb_pkg::DIV_RST;
		end else begin
			if (wr && adr == ufb_pkg::ADR_BAUD_HI) begin
				baud_hi_r <= wb_dat_i[ufb_pkg::DIV_HI_W-1:0];
			end
			// low byte write reloads prescaler now
			if (wr && adr == ufb_pkg::ADR_BAUD_LO) begin
				baud_lo_r <= wb_dat_i[7:0];
				div_r <= {baud_hi_r, wb_dat_i[7:0]};
				cnt_r <= {baud_hi_r, wb_dat_i[7:0]};
			end else if (tick) begin
				cnt_r <= div_r;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ph_r <= '0;
		end else if (tick) begin
			ph_r <= (ph_r >= os_m1) ? '0 : ph_r + 1'b1;
		end
	end

	// synchronous clock, free-running in sync mode, otherwise held at polarity level
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_r <= 1'b0;
			sync_serial_clock_oe_o <= 1'b0;
		end else begin
			sync_serial_clock_oe_o <= is_sync;
			if (!is_sync) begin
				sclk_r <= frame_r.pol;
			end else if (tick) begin
				sclk_r <= !sclk_r;
			end
		end
	end
	assign sync_serial_clock_o = sclk_r;

	// Bus answer
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= go;
			if (go) begin
				dat_r <= '0;
				unique case (adr)
					ufb_pkg::ADR_FRAME: dat_r[7:0] <= frame_r;
					ufb_pkg::ADR_ENABLE: begin
						dat_r[ufb_pkg::EN_RX_BIT] <= rx_en_r;
						dat_r[ufb_pkg::EN_TX_BIT] <= tx_en_r;
						dat_r[ufb_pkg::EN_WTOP_BIT] <= wtop_r;
					end
					ufb_pkg::ADR_STATUS: begin
						dat_r[ufb_pkg::ST_RXFULL_BIT] <= rx_full_r;
						dat_r[ufb_pkg::ST_TXRDY_BIT] <= fifo_in_ready;
						dat_r[ufb_pkg::ST_PERR_BIT] <= perr_r;
						dat_r[ufb_pkg::ST_DS_BIT] <= ds_r;
						dat_r[ufb_pkg::ST_TXBUSY_BIT] <= tx_st_r != ufb_pkg::T_IDLE;
					end
					// divisor split; unused high bits read zero
					ufb_pkg::ADR_BAUD_HI: dat_r[ufb_pkg::DIV_HI_W-1:0] <= baud_hi_r;
					ufb_pkg::ADR_BAUD_LO: dat_r[7:0] <= baud_lo_r;
					ufb_pkg::ADR_RX_DATA: dat_r[DW-1:0] <= rx_data_r;
					default: dat_r <= '0;
				endcase
			end
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// Transmitter
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			tx_st_r <= ufb_pkg::T_IDLE;
			tx_sh_r <= '0;
			tx_bit_r <= '0;
			tx_out_r <= 1'b1;
		end else if (tx_step) begin
			unique case (tx_st_r)
				ufb_pkg::T_IDLE: if (tx_pop) begin
					tx_sh_r <= fifo_out_data;
					tx_out_r <= 1'b0;
					tx_st_r <= ufb_pkg::T_START;
				end
				ufb_pkg::T_START: begin
					tx_out_r <= tx_sh_r[0];
					tx_bit_r <= '0;
					tx_st_r <= ufb_pkg::T_DATA;
				end
				ufb_pkg::T_DATA: begin
					if (tx_bit_r == nb_m1) begin
						tx_out_r <= par_en ? tx_par : 1'b1;
						tx_st_r <= par_en ? ufb_pkg::T_PAR : ufb_pkg::T_STOP;
						tx_bit_r <= '0;
					end else begin
						tx_out_r <= tx_sh_r[tx_bit_r + 4'h1];
						tx_bit_r <= tx_bit_r + 4'h1;
					end
				end
				ufb_pkg::T_PAR: begin
					tx_out_r <= 1'b1;
					tx_st_r <= ufb_pkg::T_STOP;
				end
				ufb_pkg::T_STOP: begin
					if (frame_r.stop2 && tx_bit_r == '0) begin
						tx_bit_r <= 4'h1;
					end else if (tx_pop) begin
						tx_sh_r <= fifo_out_data;
						tx_out_r <= 1'b0;
						tx_st_r <= ufb_pkg::T_START;
					end else begin
						tx_st_r <= ufb_pkg::T_IDLE;
					end
				end
				default: tx_st_r <= ufb_pkg::T_IDLE;
			endcase
		end
	end
	assign serial_out_pin_o = tx_out_r;

	// Receive pin synchroniser
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end else begin
			rx_s1_r <= serial_in_pin_i;
			rx_s2_r <= rx_s1_r;
		end
	end

	logic rx_step;
	logic [3:0] rx_tgt;
	logic rx_done;
	assign rx_tgt = (rx_st_r == ufb_pkg::R_START) ? half_m1 : os_m1;
	assign rx_step = is_async ? (tick && rx_os_r == rx_tgt) : sync_rx_edge;
	assign rx_done = rx_step && rx_st_r == ufb_pkg::R_STOP;

	// Receiver
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rx_st_r <= ufb_pkg::R_IDLE;
			rx_sh_r <= '0;
			rx_bit_r <= '0;
			rx_os_r <= '0;
			rx_par_r <= 1'b0;
		end else begin
			if (tick) begin
				rx_os_r <= (rx_os_r == rx_tgt) ? '0 : rx_os_r + 1'b1;
			end
			unique case (rx_st_r)
				ufb_pkg::R_IDLE: begin
					rx_sh_r <= '0;
					rx_bit_r <= '0;
					rx_par_r <= 1'b0;
					if (rx_en_r && !rx_s2_r && is_async) begin
						rx_os_r <= '0;
						rx_st_r <= ufb_pkg::R_START;
					end else if (rx_en_r && !rx_s2_r && sync_rx_edge) begin
						rx_st_r <= ufb_pkg::R_DATA;
					end
				end
				ufb_pkg::R_START: if (rx_step) begin
					rx_st_r <= rx_s2_r ? ufb_pkg::R_IDLE : ufb_pkg::R_DATA;
				end
				ufb_pkg::R_DATA: if (rx_step) begin
					rx_sh_r[rx_bit_r] <= rx_s2_r;
					rx_par_r <= rx_par_r ^ rx_s2_r;
					rx_bit_r <= rx_bit_r + 4'h1;
					if (rx_bit_r == nb_m1) begin
						rx_st_r <= par_en ? ufb_pkg::R_PAR : ufb_pkg::R_STOP;
					end
				end
				ufb_pkg::R_PAR: if (rx_step) begin
					rx_par_r <= rx_par_r ^ rx_s2_r;
					rx_st_r <= ufb_pkg::R_STOP;
				end
				// one stop bit time waited regardless of stop select; its level is not checked
				ufb_pkg::R_STOP: if (rx_step) begin
					rx_st_r <= ufb_pkg::R_IDLE;
				end
				default: rx_st_r <= ufb_pkg::R_IDLE;
			endcase
		end
	end

	// Received word and flags; new data wins over a read
	logic rx_read;
	assign rx_read = go && !wb_we_i && adr == ufb_pkg::ADR_RX_DATA;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rx_data_r <= '0;
			rx_full_r <= 1'b0;
			perr_r <= 1'b0;
		end else if (rx_done) begin
			rx_data_r <= rx_sh_r;
			rx_full_r <= 1'b1;
			perr_r <= par_en && (rx_par_r != frame_r.parity[0]);
		end else if (rx_read) begin
			rx_full_r <= 1'b0;
			perr_r <= 1'b0;
		end
	end

	// Bit period check helper
	logic [16:0] per_cnt_r;
	logic per_arm_r;
	logic per_ok_r;
	logic cfg_chg;
	logic [16:0] per_exp;
	assign cfg_chg = (wr && (adr == ufb_pkg::ADR_BAUD_LO || adr == ufb_pkg::ADR_STATUS));
	assign per_exp = 17'((17'(div_r) + 17'h1) * (17'(os_m1) + 17'h1) - 17'h1);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			per_cnt_r <= '0;
			per_arm_r <= 1'b0;
			per_ok_r <= 1'b0;
		end else if (cfg_chg) begin
			per_arm_r <= 1'b0;
			per_ok_r <= 1'b0;
		end else if (tx_bit_tick) begin
			per_cnt_r <= '0;
			per_arm_r <= 1'b1;
			per_ok_r <= per_arm_r;
		end else begin
			per_cnt_r <= per_cnt_r + 17'h1;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_DIV_LOAD: assert property (
		(wr && adr == ufb_pkg::ADR_BAUD_LO) |=>
		(div_r == {$past(baud_hi_r), $past(wb_dat_i[7:0])}) && cnt_r == div_r)
		else $error("low byte write did not load prescaler");
	AST_HI_HELD: assert property (
		(wr && adr == ufb_pkg::ADR_BAUD_HI) |=> $stable(div_r))
		else $error("high byte write changed running divisor");
	AST_HI_READ_ZERO: assert property (
		(go && !wb_we_i && adr == ufb_pkg::ADR_BAUD_HI) |=> wb_dat_o[31:4] == '0)
		else $error("unused divisor bits read nonzero");
	AST_BIT_PERIOD: assert property (
		(tx_bit_tick && per_ok_r) |-> per_cnt_r == per_exp)
		else $error("bit period wrong");
	AST_DOUBLE_SPEED: assert property (
		(ds_r && tick) |-> ph_r <= ufb_pkg::OS_DBL_M1 || !$past(ds_r, 16))
		else $error("double speed phase exceeds eight");
	AST_TX_PARITY: assert property (
		tx_st_r == ufb_pkg::T_PAR |-> serial_out_pin_o == tx_par)
		else $error("transmitted parity bit wrong");
	AST_TX_WIDTH: assert property (
		(tx_st_r == ufb_pkg::T_DATA && tx_step && tx_bit_r == nb_m1) |=>
		tx_st_r != ufb_pkg::T_DATA)
		else $error("data bit count wrong");
	AST_TWO_STOP: assert property (
		(tx_st_r == ufb_pkg::T_STOP && tx_step && tx_bit_r == '0 && frame_r.stop2) |=>
		tx_st_r == ufb_pkg::T_STOP && serial_out_pin_o)
		else $error("second stop bit missing");
	AST_RX_PERR: assert property (
		(rx_done && par_en && rx_par_r != frame_r.parity[0]) |=> perr_r && rx_full_r)
		else $error("parity error not flagged");
	AST_RX_ONE_STOP: assert property (
		rx_done |=> rx_st_r == ufb_pkg::R_IDLE)
		else $error("receiver waited on stop count");
	AST_SYNC_EDGE: assert property (
		(is_sync && $past(is_sync) && $changed(serial_out_pin_o)) |-> $past(sync_tx_edge))
		else $error("sync output changed on wrong edge");

	COV_PERR: cover property (rx_done && par_en && rx_par_r != frame_r.parity[0]);
	COV_TWO_STOP: cover property (tx_st_r == ufb_pkg::T_STOP && frame_r.stop2 && tx_bit_r != '0);
	COV_NINE_BITS: cover property (tx_pop && nb == 4'h9);
	COV_SYNC_FRAME: cover property (is_sync && rx_done);
endmodule

// ### hw/ufb_pkg.sv
// Package for the serial frame-format and baud configuration block.
// Assumes a single system clock; shared by the top module and the bench.
package ufb_pkg;
	// Register byte addresses on the Wishbone bus
	localparam logic [7:0] ADR_FRAME = 8'h00;
	localparam logic [7:0] ADR_ENABLE = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_BAUD_HI = 8'h0C;
	localparam logic [7:0] ADR_BAUD_LO = 8'h10;
	localparam logic [7:0] ADR_TX_DATA = 8'h14;
	localparam logic [7:0] ADR_RX_DATA = 8'h18;

	// Widths
	localparam int DATA_W = 9;
	localparam int FIFO_DEPTH = 16;
	localparam int DIV_W = 12;
	localparam int DIV_HI_W = 4;

	// Reset values
	localparam logic [7:0] FRAME_RST = 8'h06;
	localparam logic [DIV_W-1:0] DIV_RST = 12'h000;

	// Enable register bits
	localparam int EN_RX_BIT = 4;
	localparam int EN_TX_BIT = 3;
	localparam int EN_WTOP_BIT = 2;

	// Status register bits
	localparam int ST_RXFULL_BIT = 7;
	localparam int ST_TXRDY_BIT = 5;
	localparam int ST_PERR_BIT = 2;
	localparam int ST_DS_BIT = 1;
	localparam int ST_TXBUSY_BIT = 0;

	typedef enum logic [1:0] {
		MODE_ASYNC = 2'b00,
		MODE_SYNC = 2'b01,
		MODE_RSVD = 2'b10,
		MODE_SPI = 2'b11
	} ufb_mode_t;

	localparam logic [1:0] PAR_OFF = 2'b00;
	localparam logic [1:0] PAR_EVEN = 2'b10;
	localparam logic [1:0] PAR_ODD = 2'b11;

	// Character width codes, top bit first
	localparam logic [2:0] WID_5 = 3'h0;
	localparam logic [2:0] WID_6 = 3'h1;
	localparam logic [2:0] WID_7 = 3'h2;
	localparam logic [2:0] WID_8 = 3'h3;
	localparam logic [2:0] WID_9 = 3'h7;

	// Oversampling: ticks per bit minus one, and to mid-bit minus one
	localparam logic [3:0] OS_NORM_M1 = 4'hF;
	localparam logic [3:0] OS_DBL_M1 = 4'h7;
	localparam logic [3:0] HALF_NORM_M1 = 4'h7;
	localparam logic [3:0] HALF_DBL_M1 = 4'h3;

	typedef struct packed {
		ufb_mode_t mode;
		logic [1:0] parity;
		logic stop2;
		logic [1:0] width_lo;
		logic pol;
	} ufb_frame_t;

	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_START = 3'b001,
		T_DATA = 3'b010,
		T_PAR = 3'b011,
		T_STOP = 3'b100
	} ufb_tx_st_t;

	typedef enum logic [2:0] {
		R_IDLE = 3'b000,
		R_START = 3'b001,
		R_DATA = 3'b010,
		R_PAR = 3'b011,
		R_STOP = 3'b100
	} ufb_rx_st_t;
endpackage

// ### hw/ufb_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module ufb_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic push;
	logic pop;

	assign in_ready_o = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_r[rd_ptr_r];

	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_sys_i or posedge rst_i) begin
			if (rst_i) begin
				mem_r[i] <= '0;
			end else if (push && wr_ptr_r == AW'(i)) begin
				mem_r[i] <= in_data_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule

// ### dv/ufb_node.sv
// Remote serial node: samples frames from the block and sends frames to it.
// Assumes the bench sets the bit length in clocks and the frame length in bits.
`timescale 1ns/1ps
module ufb_node (
	// Clock
	input wire logic clk_sys_i,
	// Line from and to the block
	input wire logic line_i,
	output logic line_o
);
	int bit_clk = 32;
	int n_bits = 10;
	longint cyc = 0;
	logic [15:0] got_q[$];
	longint t_q[$];
	initial line_o = 1'b1;
	always @(posedge clk_sys_i) cyc <= cyc + 1;
	initial begin : capture
		logic [15:0] v;
		forever begin
			@(posedge clk_sys_i);
			if (line_i === 1'b0) begin
				t_q.push_back(cyc);
				v = '0;
				repeat (bit_clk / 2) @(posedge clk_sys_i);
				for (int i = 0; i < n_bits; i++) begin
					v[i] = line_i;
					if (i < n_bits - 1)
						repeat (bit_clk) @(posedge clk_sys_i);
				end
				got_q.push_back(v);
			end
		end
	end
	task automatic send(input logic [15:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			line_o <= bits[i];
			repeat (bit_clk) @(posedge clk_sys_i);
		end
		line_o <= 1'b1;
	endtask
endmodule

// ### dv/ufb_top_bench.sv
// Self-checking bench for frame format, divisor, modes and FIFO.
// Assumes the remote node model on the serial pins, 100 MHz clock.
`timescale 1ns/1ps
module ufb_top_bench;
	logic clk_sys_i;
	logic rst_i;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic serial_in_pin_i;
	logic serial_out_pin_o;
	logic sync_serial_clock_o;
	logic sync_serial_clock_oe_o;
	int err_count = 0;
	int n_compared = 0;
	int seed = 32'h00cd;
	int toggles = 0;
	int bad_edges = 0;
	logic sync_on = 1'b0;
	logic quiet_on = 1'b0;
	logic pol_r = 1'b0;
	logic prev_out;
	logic prev_clk;
	logic [31:0] q;
	logic [15:0] exp_q[$];
	int wtab[5] = '{5, 6, 7, 8, 9};
	logic [2:0] wctab[5] = '{ufb_pkg::WID_5, ufb_pkg::WID_6, ufb_pkg::WID_7,
		ufb_pkg::WID_8, ufb_pkg::WID_9};
	logic [1:0] ptab[3] = '{ufb_pkg::PAR_OFF, ufb_pkg::PAR_EVEN, ufb_pkg::PAR_ODD};

	ufb_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
		.sync_serial_clock_o(sync_serial_clock_o),
		.sync_serial_clock_oe_o(sync_serial_clock_oe_o));
	ufb_node node (.clk_sys_i(clk_sys_i), .line_i(serial_out_pin_o), .line_o(serial_in_pin_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		err_count++;
		$display("ERROR run timed out");
		report_and_stop();
	end
	// Watch the serial output against the sync clock
	always @(posedge clk_sys_i) begin
		prev_out <= serial_out_pin_o;
		prev_clk <= sync_serial_clock_o;
		if (sync_on && serial_out_pin_o !== prev_out && sync_serial_clock_o !== ~pol_r)
			bad_edges++;
		if (sync_on && sync_serial_clock_o !== prev_clk)
			toggles++;
		if (quiet_on && serial_out_pin_o !== 1'b1)
			bad_edges++;
	end

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
		input logic [3:0] sel, output logic [31:0] rq);
		int t;
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		wb_sel_i <= sel;
		t = 0;
		do begin
			@(posedge clk_sys_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 100);
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (t >= 100) begin
			err_count++;
			$display("ERROR bus wait timed out");
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		wb(1'b1, adr, d, 4'h1, q);
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] m);
		wb(1'b0, adr, 32'h0, 4'h1, q);
		check($sformatf("reg %h", adr), q & m, exp);
	endtask
	task automatic cfg(input logic [1:0] m, input logic [1:0] p, input logic s2,
		input logic [2:0] wc, input logic pol, input logic ds);
		wr(ufb_pkg::ADR_FRAME, {24'h0, m, p, s2, wc[1:0], pol});
		wr(ufb_pkg::ADR_ENABLE, {27'h0, 1'b1, 1'b1, wc[2], 2'b00});
		wr(ufb_pkg::ADR_STATUS, {30'h0, ds, 1'b0});
	endtask
	function automatic logic [15:0] frame_bits(input int d, input int w, input logic [1:0] pc,
		input int st, output int n);
		logic [15:0] b;
		logic p;
		b = 16'hFFFF;
		b[0] = 1'b0;
		p = 1'b0;
		n = 1;
		for (int i = 0; i < w; i++) begin
			b[n] = d[i];
			p = p ^ d[i];
			n++;
		end
		if (pc[1]) begin
			b[n] = p ^ pc[0];
			n++;
		end
		n += st;
		return b;
	endfunction
	task automatic wait_frames(input int cnt);
		int t;
		t = 0;
		while (node.got_q.size() < cnt && t < 60000) begin
			@(posedge clk_sys_i);
			t++;
		end
		if (t >= 60000) begin
			err_count++;
			$display("ERROR frame wait timed out");
			report_and_stop();
		end
	endtask
	task automatic push_tx(input int cnt, input int w, input logic [1:0] pc, input int st);
		int d;
		int n;
		for (int j = 0; j < cnt; j++) begin
			d = $random(seed) & ((1 << w) - 1);
			exp_q.push_back(frame_bits(d, w, pc, st, n));
			node.n_bits = n;
			wr(ufb_pkg::ADR_TX_DATA, 32'(d));
		end
	endtask
	task automatic check_tx(input int cnt);
		logic [15:0] m;
		wait_frames(cnt);
		m = 16'((32'h1 << node.n_bits) - 32'h1);
		for (int j = 0; j < cnt; j++)
			check("tx frame", 32'(node.got_q.pop_front()), 32'(exp_q.pop_front() & m));
		node.t_q.delete();
		repeat (node.bit_clk) @(posedge clk_sys_i);
	endtask

	initial begin
		int w;
		int st;
		int bc;
		int n;
		int d;
		int dt;
		logic [1:0] pc;
		logic [15:0] fb;
		logic bad;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++)
			rd_chk(8'(4 * i), i == 0 ? {24'h0, ufb_pkg::FRAME_RST} : (i == 2 ? 32'h20 : 32'h0),
				32'hFFFFFFFF);
		wb(1'b1, ufb_pkg::ADR_FRAME, 32'hFF, 4'h0, q);
		rd_chk(ufb_pkg::ADR_FRAME, {24'h0, ufb_pkg::FRAME_RST}, 32'hFFFFFFFF);
		wr(ufb_pkg::ADR_BAUD_HI, 32'h0F);
		rd_chk(ufb_pkg::ADR_BAUD_HI, 32'h0F, 32'hFFFFFFFF);
		wr(ufb_pkg::ADR_BAUD_HI, 32'h0);
		wr(ufb_pkg::ADR_BAUD_LO, 32'h1);
		$display("test registers done");
		for (int k = 0; k < 6; k++) begin
			w = wtab[k % 5];
			pc = ptab[k % 3];
			st = k % 2 + 1;
			bc = (k >= 3) ? 16 : 32;
			cfg(ufb_pkg::MODE_ASYNC, pc, st == 2, wctab[k % 5], 1'b0, k >= 3);
			node.bit_clk = bc;
			push_tx(2, w, pc, st);
			void'(frame_bits(0, w, pc, st, n));
			wait_frames(2);
			dt = int'(node.t_q[1] - node.t_q[0]);
			check("frame spacing", 32'(dt >= n * bc && dt < n * bc + bc / 2), 32'h1);
			check_tx(2);
			d = $random(seed) & ((1 << w) - 1);
			fb = frame_bits(d, w, pc, 1, n);
			bad = k % 2 == 1 && pc[1];
			fb[1 + w] = fb[1 + w] ^ bad;
			node.send(fb, n);
			repeat (bc) @(posedge clk_sys_i);
			rd_chk(ufb_pkg::ADR_STATUS, {24'h0, 1'b1, 4'h0, bad, 2'b00}, 32'h84);
			rd_chk(ufb_pkg::ADR_RX_DATA, 32'(d), 32'h1FF);
		end
		$display("test formats done");
		cfg(ufb_pkg::MODE_ASYNC, ufb_pkg::PAR_OFF, 1'b0, ufb_pkg::WID_8, 1'b0, 1'b1);
		wr(ufb_pkg::ADR_BAUD_HI, 32'h1);
		node.bit_clk = 16;
		push_tx(1, 8, ufb_pkg::PAR_OFF, 1);
		check_tx(1);
		wr(ufb_pkg::ADR_BAUD_LO, 32'h0);
		node.bit_clk = 257 * 8;
		push_tx(1, 8, ufb_pkg::PAR_OFF, 1);
		check_tx(1);
		wr(ufb_pkg::ADR_BAUD_HI, 32'h0);
		wr(ufb_pkg::ADR_BAUD_LO, 32'h3);
		$display("test divisor done");
		node.bit_clk = 8;
		for (int p = 0; p < 2; p++) begin
			cfg(ufb_pkg::MODE_SYNC, ufb_pkg::PAR_OFF, 1'b0, ufb_pkg::WID_8, p[0], 1'b0);
			pol_r <= p[0];
			repeat (2) @(posedge clk_sys_i);
			check("clock enable", 32'(sync_serial_clock_oe_o), 32'h1);
			d = toggles;
			sync_on <= 1'b1;
			wr(ufb_pkg::ADR_TX_DATA, 32'($random(seed) & 32'hFF));
			repeat (200) @(posedge clk_sys_i);
			sync_on <= 1'b0;
			check("sync edges", 32'(bad_edges), 32'h0);
			check("sync toggles", 32'(toggles > d), 32'h1);
		end
		node.got_q.delete();
		node.t_q.delete();
		$display("test sync done");
		cfg(ufb_pkg::MODE_SPI, ufb_pkg::PAR_OFF, 1'b0, ufb_pkg::WID_8, 1'b0, 1'b0);
		quiet_on <= 1'b1;
		push_tx(16, 8, ufb_pkg::PAR_OFF, 1);
		rd_chk(ufb_pkg::ADR_STATUS, 32'h0, 32'h20);
		repeat (200) @(posedge clk_sys_i);
		quiet_on <= 1'b0;
		check("quiet line", 32'(bad_edges + node.got_q.size()), 32'h0);
		check("clock enable", 32'(sync_serial_clock_oe_o), 32'h0);
		node.bit_clk = 64;
		cfg(ufb_pkg::MODE_ASYNC, ufb_pkg::PAR_OFF, 1'b0, ufb_pkg::WID_8, 1'b0, 1'b0);
		check_tx(16);
		rd_chk(ufb_pkg::ADR_STATUS, 32'h20, 32'h20);
		$display("test fifo done");
		report_and_stop();
	end
endmodule
